/* File: hdl/gpio_pkg.sv */
// Constants, field layouts and carrier types for the pin group controller.
// Assumes one 32-pin group per instance, addressed through a byte address.
package gpio_pkg;

  localparam int NPINS = 32;
  localparam int NEVT = 4;
  localparam int ADDR_W = 10;

  // Word offsets inside one group window
  localparam logic [6:0] OFS_DIR = 7'h00;
  localparam logic [6:0] OFS_DIR_CLR = 7'h04;
  localparam logic [6:0] OFS_DIR_SET = 7'h08;
  localparam logic [6:0] OFS_DIR_TGL = 7'h0C;
  localparam logic [6:0] OFS_OUT = 7'h10;
  localparam logic [6:0] OFS_OUT_CLR = 7'h14;
  localparam logic [6:0] OFS_OUT_SET = 7'h18;
  localparam logic [6:0] OFS_OUT_TGL = 7'h1C;
  localparam logic [6:0] OFS_IN = 7'h20;
  localparam logic [6:0] OFS_CTRL = 7'h24;
  localparam logic [6:0] OFS_EVCTRL = 7'h2C;
  localparam logic [2:0] OFS_ALTSEL_HI = 3'h3;  // 0x30..0x3C, nibble per pad
  localparam logic [1:0] OFS_PADCFG_HI = 2'h2;  // 0x40..0x5C, byte per pad
  localparam int GROUP_SHIFT = 7;               // group windows 0x80 apart

  // Per-pad configuration byte
  localparam int CFG_ALT_EN_BIT = 0;
  localparam int CFG_SAMPLER_BIT = 1;
  localparam int CFG_RESISTOR_BIT = 2;
  localparam logic [7:0] CFG_WMASK = 8'h07;

  // Event control byte per event input
  localparam int EV_PAD_LSB = 0;
  localparam int EV_ACT_LSB = 5;
  localparam int EV_EN_BIT = 7;

  // Reset values
  localparam logic [31:0] RST_DIR = 32'h0000_0000;
  localparam logic [31:0] RST_OUT = 32'h0000_0000;
  localparam logic [3:0] RST_CTRL = 4'h0;
  localparam logic [7:0] RST_PADCFG = 8'h00;
  localparam logic [3:0] RST_ALTSEL = 4'h0;
  localparam logic [31:0] RST_EVCTRL = 32'h0000_0000;

  // Timing counts in port clock cycles
  localparam int SYNC_WAIT_CYCLES = 2;
  localparam int EVENT_ACT_MAX_CYCLES = 3;

  typedef enum logic [1:0] {
    ACT_FOLLOW = 2'h0,
    ACT_SET = 2'h1,
    ACT_CLEAR = 2'h2,
    ACT_TOGGLE = 2'h3
  } evt_act_e;

  typedef enum logic [1:0] {
    SB_IDLE = 2'h0,
    SB_SYNC1 = 2'h1,
    SB_SYNC2 = 2'h3
  } sb_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic write;
    logic read;
  } bus_req_s;

  typedef struct packed {
    logic [NPINS-1:0] level;
    logic [NPINS-1:0] oe;
    logic [NPINS-1:0] pull_en;
    logic [NPINS-1:0] pull_up;
    logic [NPINS-1:0] ibuf_en;
  } pad_drive_s;

endpackage

/* File: hdl/gpio_pin_group_controller.sv */
// One 32-pin group: direction, level, pad config, alternate hand-off, events.
// Assumes the system decoder routes both ports to every group instance.
//
// Design decisions made here: strobed register access and the address map.

`timescale 1ns/100ps

module gpio_pin_group_controller import gpio_pkg::*; #(
  parameter logic [2:0] GROUP_INDEX = 3'h0
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire bus_req_s CPU_REQ_I,
  output logic [31:0] CPU_RDATA_O,
  input wire bus_req_s SB_REQ_I,
  output logic SB_READY_O,
  output logic [31:0] SB_RDATA_O,
  input wire logic [NPINS-1:0] PAD_IN_I,
  output pad_drive_s PAD_O,
  input wire logic [NPINS-1:0] ALT_OUT_I,
  input wire logic [NPINS-1:0] ALT_OE_I,
  output logic [NPINS-1:0][3:0] ALT_SEL_O,
  input wire logic [NEVT-1:0] EVENT_I,
  input wire logic STANDBY_I
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [31:0] dir_reg, dir_next;
  logic [31:0] out_reg, out_next;
  logic [3:0] ctrl_reg, ctrl_next;
  logic [NPINS-1:0][7:0] padcfg_reg, padcfg_next;
  logic [NPINS-1:0][3:0] altsel_reg, altsel_next;
  logic [31:0] evctrl_reg, evctrl_next;
  logic [NPINS-1:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
  logic [NEVT-1:0] evt_s1_reg, evt_s2_reg, evt_prev_reg, evt_pend_reg, evt_pend_next;
  sb_state_e sb_state_reg, sb_state_next;
  logic [31:0] cpu_rdata_reg, cpu_rdata_next, sb_rdata_reg, sb_rdata_next;

  logic cpu_busy, sb_hit_in, sb_accept, wr_en, evt_apply;
  bus_req_s wreq;
  logic [NPINS-1:0] samp_mask, alt_mask, samp_run, follow_hit, follow_lvl;
  logic [NEVT-1:0] evt_rise, evt_fire;
  logic [NPINS-1:0][7:0] cfg_view;

  function automatic logic in_group(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:GROUP_SHIFT] == GROUP_INDEX;
  endfunction

  function automatic logic [6:0] ofs_of(input logic [ADDR_W-1:0] a);
    return a[6:0];
  endfunction

  always_comb begin
    for (int p = 0; p < NPINS; p++) begin
      samp_mask[p] = padcfg_reg[p][CFG_SAMPLER_BIT];
      alt_mask[p] = padcfg_reg[p][CFG_ALT_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration: local CPU port always goes, system bus waits behind it
  assign cpu_busy = CPU_REQ_I.write | CPU_REQ_I.read;
  assign sb_hit_in = SB_REQ_I.read & in_group(SB_REQ_I.addr) & (ofs_of(SB_REQ_I.addr) == OFS_IN);

  always_comb begin
    sb_state_next = sb_state_reg;
    SB_READY_O = 1'b0;
    case (sb_state_reg)
      SB_IDLE: begin
        if (sb_hit_in && ctrl_reg != 4'hF) begin
          sb_state_next = SB_SYNC1;
        end else begin
          SB_READY_O = ~cpu_busy;
        end
      end
      SB_SYNC1: sb_state_next = SB_SYNC2;
      SB_SYNC2: begin
        SB_READY_O = ~cpu_busy;
        if (!cpu_busy) begin
          sb_state_next = SB_IDLE;
        end
      end
      default: sb_state_next = SB_IDLE;
    endcase
  end

  assign sb_accept = SB_READY_O & (SB_REQ_I.write | SB_REQ_I.read);
  assign wreq = CPU_REQ_I.write ? CPU_REQ_I : SB_REQ_I;
  assign wr_en = (CPU_REQ_I.write | (SB_REQ_I.write & SB_READY_O)) & in_group(wreq.addr);
  // Events only touch the level register when no bus write hits this group this cycle
  assign evt_apply = ~wr_en;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers, clocked on demand or when always-on per eight pads
  always_comb begin
    for (int p = 0; p < NPINS; p++) begin
      samp_run[p] = ctrl_reg[p / 8] | (sb_state_reg != SB_IDLE) | sb_hit_in;
    end
    sync1_next = sync1_reg;
    sync2_next = sync2_reg;
    for (int p = 0; p < NPINS; p++) begin
      if (!samp_mask[p]) begin
        sync1_next[p] = 1'b0;
        sync2_next[p] = 1'b0;
      end else if (samp_run[p]) begin
        sync1_next[p] = PAD_IN_I[p];
        sync2_next[p] = sync1_reg[p];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads; unmapped offsets and other groups read zero
  always_comb begin
    for (int p = 0; p < NPINS; p++) begin
      cfg_view[p] = padcfg_reg[p] & CFG_WMASK;
    end
  end

  function automatic logic [31:0] read_word(input logic [6:0] o, input logic [31:0] dir_v,
                                            input logic [31:0] out_v, input logic [31:0] in_v,
                                            input logic [3:0] ctl_v, input logic [31:0] ev_v,
                                            input logic [NPINS-1:0][7:0] cfg_v,
                                            input logic [NPINS-1:0][3:0] sel_v);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (o)
      OFS_DIR, OFS_DIR_CLR, OFS_DIR_SET, OFS_DIR_TGL: r = dir_v;
      OFS_OUT, OFS_OUT_CLR, OFS_OUT_SET, OFS_OUT_TGL: r = out_v;
      OFS_IN: r = in_v;
      OFS_CTRL: r = {28'h0000000, ctl_v};
      OFS_EVCTRL: r = ev_v;
      default: begin
        if (o[6:4] == OFS_ALTSEL_HI) begin
          for (int k = 0; k < 8; k++) begin
            r[4*k +: 4] = sel_v[8*o[3:2] + k];
          end
        end else if (o[6:5] == OFS_PADCFG_HI) begin
          for (int k = 0; k < 4; k++) begin
            r[8*k +: 8] = cfg_v[4*o[4:2] + k];
          end
        end
      end
    endcase
    return r;
  endfunction

  always_comb begin
    cpu_rdata_next = 32'h0000_0000;
    sb_rdata_next = 32'h0000_0000;
    if (CPU_REQ_I.read && in_group(CPU_REQ_I.addr)) begin
      cpu_rdata_next = read_word(ofs_of(CPU_REQ_I.addr), dir_reg, out_reg, sync2_reg, ctrl_reg,
                                 evctrl_reg, cfg_view, altsel_reg);
    end
    if (sb_accept && SB_REQ_I.read && in_group(SB_REQ_I.addr)) begin
      sb_rdata_next = read_word(ofs_of(SB_REQ_I.addr), dir_reg, out_reg, sync2_reg, ctrl_reg,
                                evctrl_reg, cfg_view, altsel_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events: synchronise, detect rising edges, hold until the level is free
  assign evt_rise = evt_s2_reg & ~evt_prev_reg;

  always_comb begin
    for (int m = 0; m < NEVT; m++) begin
      evt_fire[m] = (evt_pend_reg[m] | evt_rise[m]) & evctrl_reg[8*m + EV_EN_BIT]
                    & (evctrl_reg[8*m + EV_ACT_LSB +: 2] != ACT_FOLLOW) & ~STANDBY_I;
    end
    // Standby drops pending edges rather than replaying them on wake-up
    evt_pend_next = evt_apply ? 4'h0 : evt_fire;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and event actions on the level register
  always_comb begin
    logic all_set, all_clr, any_hit, hit;
    dir_next = dir_reg;
    out_next = out_reg;
    ctrl_next = ctrl_reg;
    padcfg_next = padcfg_reg;
    altsel_next = altsel_reg;
    evctrl_next = evctrl_reg;
    all_set = 1'b0;
    all_clr = 1'b0;
    any_hit = 1'b0;
    hit = 1'b0;
    if (wr_en) begin
      case (ofs_of(wreq.addr))
        OFS_DIR: dir_next = wreq.wdata;
        OFS_DIR_CLR: dir_next = dir_reg & ~wreq.wdata;
        OFS_DIR_SET: dir_next = dir_reg | wreq.wdata;
        OFS_DIR_TGL: dir_next = dir_reg ^ wreq.wdata;
        OFS_OUT: out_next = wreq.wdata;
        OFS_OUT_CLR: out_next = out_reg & ~wreq.wdata;
        OFS_OUT_SET: out_next = out_reg | wreq.wdata;
        OFS_OUT_TGL: out_next = out_reg ^ wreq.wdata;
        OFS_CTRL: ctrl_next = wreq.wdata[3:0];
        OFS_EVCTRL: evctrl_next = wreq.wdata;
        default: begin
          if (wreq.addr[6:4] == OFS_ALTSEL_HI) begin
            for (int k = 0; k < 8; k++) begin
              altsel_next[8*wreq.addr[3:2] + k] = wreq.wdata[4*k +: 4];
            end
          end else if (wreq.addr[6:5] == OFS_PADCFG_HI) begin
            for (int k = 0; k < 4; k++) begin
              padcfg_next[4*wreq.addr[4:2] + k] = wreq.wdata[8*k +: 8] & CFG_WMASK;
            end
          end
        end
      endcase
    end else begin
      for (int p = 0; p < NPINS; p++) begin
        all_set = 1'b1;
        all_clr = 1'b1;
        any_hit = 1'b0;
        for (int m = 0; m < NEVT; m++) begin
          hit = evt_fire[m] & (evctrl_reg[8*m + EV_PAD_LSB +: 5] == 5'(p));
          any_hit = any_hit | hit;
          all_set = all_set & (~hit | (evctrl_reg[8*m + EV_ACT_LSB +: 2] == ACT_SET));
          all_clr = all_clr & (~hit | (evctrl_reg[8*m + EV_ACT_LSB +: 2] == ACT_CLEAR));
        end
        if (any_hit) begin
          out_next[p] = all_set ? 1'b1 : (all_clr ? 1'b0 : ~out_reg[p]);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Follow events go straight to the pad, lowest event input wins
  always_comb begin
    follow_hit = '0;
    follow_lvl = '0;
    for (int p = 0; p < NPINS; p++) begin
      for (int m = NEVT - 1; m >= 0; m--) begin
        if (evctrl_reg[8*m + EV_EN_BIT] && evctrl_reg[8*m + EV_ACT_LSB +: 2] == ACT_FOLLOW &&
            evctrl_reg[8*m + EV_PAD_LSB +: 5] == 5'(p)) begin
          follow_hit[p] = 1'b1;
          follow_lvl[p] = EVENT_I[m];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive; combinational so follow events see no latency
  always_comb begin
    for (int p = 0; p < NPINS; p++) begin
      PAD_O.oe[p] = alt_mask[p] ? ALT_OE_I[p] : dir_reg[p];
      PAD_O.level[p] = alt_mask[p] ? ALT_OUT_I[p] : (follow_hit[p] ? follow_lvl[p] : out_reg[p]);
      PAD_O.pull_en[p] = padcfg_reg[p][CFG_RESISTOR_BIT] & ~PAD_O.oe[p];
      PAD_O.pull_up[p] = out_reg[p];
      // Peripherals read the pad too, so their hand-off keeps the buffer on
      PAD_O.ibuf_en[p] = samp_mask[p] | alt_mask[p];
    end
  end

  assign ALT_SEL_O = altsel_reg;
  assign CPU_RDATA_O = cpu_rdata_reg;
  assign SB_RDATA_O = sb_rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Flops; async reset gives a safe pad state without any clock
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dir_reg <= RST_DIR;
      out_reg <= RST_OUT;
      ctrl_reg <= RST_CTRL;
      padcfg_reg <= {NPINS{RST_PADCFG}};
      altsel_reg <= {NPINS{RST_ALTSEL}};
      evctrl_reg <= RST_EVCTRL;
      sync1_reg <= '0;
      sync2_reg <= '0;
      evt_s1_reg <= '0;
      evt_s2_reg <= '0;
      evt_prev_reg <= '0;
      evt_pend_reg <= '0;
      sb_state_reg <= SB_IDLE;
      cpu_rdata_reg <= 32'h0000_0000;
      sb_rdata_reg <= 32'h0000_0000;
    end else begin
      dir_reg <= dir_next;
      out_reg <= out_next;
      ctrl_reg <= ctrl_next;
      padcfg_reg <= padcfg_next;
      altsel_reg <= altsel_next;
      evctrl_reg <= evctrl_next;
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      evt_s1_reg <= EVENT_I;
      evt_s2_reg <= evt_s1_reg;
      evt_prev_reg <= evt_s2_reg;
      evt_pend_reg <= evt_pend_next;
      sb_state_reg <= sb_state_next;
      cpu_rdata_reg <= cpu_rdata_next;
      sb_rdata_reg <= sb_rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic cpu_wr_here;
  assign cpu_wr_here = CPU_REQ_I.write & in_group(CPU_REQ_I.addr);

  property p_dir_set;
    @(posedge CLK_I) disable iff (!RST_N_I)
    cpu_wr_here && ofs_of(CPU_REQ_I.addr) == OFS_DIR_SET
      |=> dir_reg == ($past(dir_reg) | $past(CPU_REQ_I.wdata));
  endproperty
  a_dir_set: assert property (p_dir_set) else $error("drive-enable set strobe wrong");

  property p_out_tgl;
    @(posedge CLK_I) disable iff (!RST_N_I)
    cpu_wr_here && ofs_of(CPU_REQ_I.addr) == OFS_OUT_TGL
      |=> out_reg == ($past(out_reg) ^ $past(CPU_REQ_I.wdata));
  endproperty
  a_out_tgl: assert property (p_out_tgl) else $error("level toggle strobe wrong");

  property p_oe_dir;
    @(posedge CLK_I) disable iff (!RST_N_I)
    ~alt_mask[0] |-> PAD_O.oe[0] == dir_reg[0] && (!dir_reg[0] || follow_hit[0] || PAD_O.level[0] == out_reg[0]);
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("pad 0 drive does not follow registers");

  property p_pull_off;
    @(posedge CLK_I) disable iff (!RST_N_I)
    (PAD_O.oe & PAD_O.pull_en) == '0;
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("resistor on while driving");

  property p_sampler_off;
    @(posedge CLK_I) disable iff (!RST_N_I)
    (~$past(samp_mask) & sync2_reg) == '0;
  endproperty
  a_sampler_off: assert property (p_sampler_off) else $error("disabled sampler produced a level");

  property p_cpu_first;
    @(posedge CLK_I) disable iff (!RST_N_I)
    cpu_busy |-> !SB_READY_O;
  endproperty
  a_cpu_first: assert property (p_cpu_first) else $error("system bus served during local access");

  property p_in_wait;
    @(posedge CLK_I) disable iff (!RST_N_I)
    sb_state_reg == SB_IDLE && sb_hit_in && ctrl_reg != 4'hF |-> !SB_READY_O ##1 !SB_READY_O ##1
      sb_state_reg == SB_SYNC2;
  endproperty
  a_in_wait: assert property (p_in_wait) else $error("on-demand read did not wait two cycles");

  property p_standby;
    @(posedge CLK_I) disable iff (!RST_N_I)
    STANDBY_I && !wr_en |=> out_reg == $past(out_reg);
  endproperty
  a_standby: assert property (p_standby) else $error("event action in standby");

  property p_evt_latency;
    @(posedge CLK_I) disable iff (!RST_N_I)
    $rose(EVENT_I[0]) ##2 (evt_rise[0] && evt_fire == 4'h1 && evctrl_reg[EV_ACT_LSB +: 2] == ACT_SET && !wr_en)
      |=> out_reg[evctrl_reg[EV_PAD_LSB +: 5]];
  endproperty
  a_evt_latency: assert property (p_evt_latency) else $error("set event missed its pad in three cycles");

  property p_follow;
    @(posedge CLK_I) disable iff (!RST_N_I)
    evctrl_reg[EV_EN_BIT] && evctrl_reg[EV_ACT_LSB +: 2] == ACT_FOLLOW && !alt_mask[evctrl_reg[4:0]]
      |-> PAD_O.level[evctrl_reg[4:0]] == EVENT_I[0];
  endproperty
  a_follow: assert property (p_follow) else $error("follow event 0 not on its pad");

  c_in_wait: cover property (@(posedge CLK_I) disable iff (!RST_N_I) sb_state_reg == SB_SYNC2 && SB_READY_O);
  c_collide: cover property (@(posedge CLK_I) disable iff (!RST_N_I) cpu_busy && SB_REQ_I.write);
  c_evt_held: cover property (@(posedge CLK_I) disable iff (!RST_N_I) |evt_pend_reg);
  c_toggle_mix: cover property (@(posedge CLK_I) disable iff (!RST_N_I) evt_apply && ($countones(evt_fire) > 1));

endmodule

/* File: tb/pad_model.sv */
// Far side of one pin group: pad wires with resistors, plus peripheral drive.
// Assumes the port clock as the only clock; pads see the design's pad drive.
`timescale 1ns/100ps
module pad_model import gpio_pkg::*; (
  input wire logic clk_i,
  input wire pad_drive_s pad_i,
  output logic [NPINS-1:0] pad_in_o,
  output logic [NPINS-1:0] alt_out_o,
  output logic [NPINS-1:0] alt_oe_o
);
  logic [NPINS-1:0] float_reg = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // An undriven pad wanders every cycle, so a missing resistor shows up
  always_ff @(posedge clk_i) begin
    float_reg <= ~float_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Peripherals drive only the upper half, always ready to take the pad
  assign alt_out_o = 32'hAAAA_AAAA;
  assign alt_oe_o = 32'hFFFF_0000;

  // Driver beats resistor, resistor beats a floating line
  assign pad_in_o = (pad_i.oe & pad_i.level) | (~pad_i.oe & pad_i.pull_en & pad_i.pull_up)
                  | (~pad_i.oe & ~pad_i.pull_en & float_reg);
endmodule

/* File: tb/gpio_pin_group_controller_tb.sv */
// Self-checking bench for group 0: bus tasks, pad model, event stimulus.
// Assumes the package and design are compiled first; no other groups present.
`timescale 1ns/100ps
module gpio_pin_group_controller_tb import gpio_pkg::*; ;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  bus_req_s cpu_req = '0;
  bus_req_s sb_req = '0;
  logic [31:0] cpu_rdata;
  logic [31:0] sb_rdata;
  logic sb_ready;
  pad_drive_s pad;
  logic [NPINS-1:0] pad_in;
  logic [NPINS-1:0] alt_out;
  logic [NPINS-1:0] alt_oe;
  logic [NPINS-1:0][3:0] alt_sel;
  logic [NEVT-1:0] evt_lvl = 4'h0;
  logic standby = 1'b0;
  int error_cnt = 0;
  int check_count = 0;
  int waits;
  logic [31:0] q;
  logic [7:0] acts [7] = '{8'h55, 8'hA9, 8'hAA, 8'h56, 8'h5F, 8'h55, 8'h55};
  logic [3:0] ens [7] = '{4'hF, 4'h1, 4'hF, 4'hF, 4'h3, 4'h0, 4'hF};
  logic exps [7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

  always #20 clk = ~clk;

  gpio_pin_group_controller #(.GROUP_INDEX(3'h0)) DUT (.CLK_I(clk), .RST_N_I(rst_n),
    .CPU_REQ_I(cpu_req), .CPU_RDATA_O(cpu_rdata), .SB_REQ_I(sb_req), .SB_READY_O(sb_ready),
    .SB_RDATA_O(sb_rdata), .PAD_IN_I(pad_in), .PAD_O(pad), .ALT_OUT_I(alt_out),
    .ALT_OE_I(alt_oe), .ALT_SEL_O(alt_sel), .EVENT_I(evt_lvl), .STANDBY_I(standby));
  pad_model pads (.clk_i(clk), .pad_i(pad), .pad_in_o(pad_in), .alt_out_o(alt_out),
    .alt_oe_o(alt_oe));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    cpu_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge clk);
    cpu_req <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic chkrd(input string nm, input logic [9:0] a, input logic [31:0] exp);
    @(posedge clk);
    cpu_req <= '{addr: a, wdata: 32'h0, write: 1'b0, read: 1'b1};
    @(posedge clk);
    cpu_req <= '0;
    #1;
    chk(nm, cpu_rdata, exp);
  endtask

  // Ready is looked at mid-cycle, so the accepting edge is never raced
  task automatic sb(input logic [9:0] a, input logic [31:0] d, input logic w);
    waits = 0;
    @(posedge clk);
    sb_req <= '{addr: a, wdata: d, write: w, read: !w};
    @(negedge clk);
    while (sb_ready !== 1'b1 && waits < 20) begin
      waits++;
      @(negedge clk);
    end
    if (waits >= 20) error_cnt++;
    @(posedge clk);
    sb_req <= '0;
    #1;
    q = sb_rdata;
  endtask

  // All four event inputs aimed at pad 9, then one rising edge on each
  task automatic evt(input logic [7:0] act, input logic [3:0] en);
    logic [31:0] c;
    for (int m = 0; m < 4; m++) c[m*8 +: 8] = {en[m], act[m*2 +: 2], 5'h09};
    wr({3'h0, OFS_EVCTRL}, c);
    @(posedge clk);
    evt_lvl <= 4'hF;
    repeat (5) @(posedge clk);
    evt_lvl <= 4'h0;
    repeat (4) @(posedge clk);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge clk);
    chk("reset oe", pad.oe, 32'h0);
    chk("reset ibuf pull", pad.ibuf_en | pad.pull_en, 32'h0);
    rst_n <= 1'b1;
    chkrd("dir reset", 10'h000, RST_DIR);
    wr(10'h008, 32'h0000_0005);
    wr(10'h004, 32'h0000_0001);
    chkrd("dir", 10'h000, 32'h0000_0004);
    chk("oe", pad.oe, 32'h0000_0004);
    wr(10'h018, 32'h0000_00F0);
    wr(10'h014, 32'h0000_0030);
    wr(10'h01C, 32'h0000_0081);
    chkrd("out", 10'h010, 32'h0000_0041);
    wr(10'h090, 32'hFFFF_FFFF);
    chkrd("other group", 10'h010, 32'h0000_0041);
    chkrd("unmapped", 10'h028, 32'h0);
    $display("test direction and level done");
    wr(10'h040, 32'h0606_0606);
    wr(10'h024, 32'h0000_0001);
    repeat (4) @(negedge clk);
    chk("pull_en", pad.pull_en, 32'h0000_000B);
    chk("pull_up", pad.pull_up & pad.pull_en, 32'h0000_0001);
    chk("ibuf", pad.ibuf_en, 32'h0000_000F);
    chkrd("in", 10'h020, 32'h0000_0001);
    wr(10'h01C, 32'h0000_0004);
    #1;
    chk("level", pad.level & pad.oe, 32'h0000_0004);
    repeat (3) @(negedge clk);
    chkrd("in of output", 10'h020, 32'h0000_0005);
    wr(10'h024, 32'h0);
    sb(10'h020, 32'h0, 1'b0);
    chk("sync wait", waits, SYNC_WAIT_CYCLES);
    chk("sb in", q, 32'h0000_0005);
    fork
      sb(10'h014, 32'h0010_0000, 1'b1);
      wr(10'h018, 32'h0010_0000);
    join
    chk("sb stall", waits, 1);
    chkrd("access order", 10'h010, 32'h0000_0045);
    $display("test pads and ports done");
    wr(10'h050, 32'h0000_0100);
    wr(10'h038, 32'h0000_0050);
    #1;
    chk("alt oe", pad.oe[17:16], 32'h2);
    chk("alt level", pad.level[17], 32'h1);
    chk("alt select", alt_sel[17], 32'h5);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk) standby <= (i == 6);
      evt(acts[i], ens[i]);
      chkrd("event", 10'h010, {22'h0, exps[i], 9'h045});
    end
    // Events 0..2 follow pad 10, event 3 disabled; event 0 must win
    wr(10'h02C, 32'h0A8A_8A8A);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      evt_lvl <= (i == 0) ? 4'hE : ((i == 1) ? 4'h1 : 4'h8);
      #1;
      chk("follow", pad.level[10], (i == 1) ? 32'h1 : 32'h0);
    end
    $display("test events done");
    give_verdict();
  end
endmodule
